// ==== rtl/cod_map.svh ====
`ifndef COD_MAP_SVH
`define COD_MAP_SVH
// apb register byte offsets
`define COD_OFF_CTRL    12'h000
`define COD_OFF_STATUS  12'h004
`define COD_OFF_DACC    12'h008
`define COD_OFF_IDX_X   12'h00c
`define COD_OFF_IDX_Y   12'h010
`define COD_OFF_STACK   12'h014
`define COD_OFF_PC      12'h018
`define COD_OFF_FLAGS   12'h01c
// control fields
`define COD_CTRL_RUN    0
`define COD_CTRL_TEST   1
// status fields
`define COD_STAT_WAIT   4
`define COD_STAT_TEST   5
// flag register bit positions
`define COD_CCR_X       6
`define COD_CCR_I       4
`define COD_CCR_N       3
`define COD_CCR_Z       2
`define COD_CCR_V       1
`define COD_CCR_C       0
// reset values
`define COD_CCR_RST     8'hd0
`define COD_SP_RST      16'h00ff
`define COD_PC_RST      16'h0000
`define COD_CTRL_RST    2'h0
// timing counts
`define COD_WAI_CYC     12
`define COD_STACK_BYTES 9
`define COD_VEC_CYC     2
// opcodes and prebytes
`define COD_PRE_Y       8'h18
`define COD_PRE_1A      8'h1a
`define COD_PRE_CD      8'hcd
`define COD_OP_TEST     8'h00
`define COD_OP_TAP      8'h06
`define COD_OP_BRA      8'h20
`define COD_OP_TSX      8'h30
`define COD_OP_TXS      8'h35
`define COD_OP_WAI      8'h3e
`endif

// ==== rtl/cod_pkg.sv ====
package cod_pkg;
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_OPC   = 4'h1,
    ST_OP1   = 4'h2,
    ST_OP2   = 4'h3,
    ST_IDX   = 4'h4,
    ST_RD1   = 4'h5,
    ST_RD2   = 4'h6,
    ST_WR1   = 4'h7,
    ST_WR2   = 4'h8,
    ST_INT   = 4'h9,
    ST_STACK = 4'ha,
    ST_WAIT  = 4'hb,
    ST_VEC1  = 4'hc,
    ST_VEC2  = 4'hd,
    ST_TEST  = 4'he
  } cod_state_t;
  // addressing mode from opcode bits 5:4
  typedef enum logic [1:0] {
    AM_IMM = 2'h0,
    AM_DIR = 2'h1,
    AM_IDX = 2'h2,
    AM_EXT = 2'h3
  } cod_amode_t;
endpackage

// ==== rtl/cod_sub.sv ====
// subtract with borrow in, flags out
module cod_sub #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] a,     // minuend
  input  wire logic [W-1:0] b,     // subtrahend
  input  wire logic         cin,   // borrow in
  output logic      [W-1:0] res,   // difference
  output logic              n,     // negative
  output logic              z,     // zero
  output logic              v,     // overflow
  output logic              c      // borrow out
);
  logic [W:0] full;                // difference with borrow bit

  assign full = {1'b0, a} - {1'b0, b} - {{W{1'b0}}, cin};
  assign res  = full[W-1:0];
  assign c    = full[W];
  assign n    = res[W-1];
  assign z    = (res == '0);
  assign v    = (a[W-1] ^ b[W-1]) & (a[W-1] ^ res[W-1]);
endmodule

// ==== rtl/cod_core.sv ====
// Decided for this implementation: register access over APB and the address map.
`include "cod_map.svh"
module cod_core #(
  parameter logic [15:0] VEC_ADDR = 16'hfff2   // interrupt vector address
) (
  input  wire logic        ref_clk,      // system clock
  input  wire logic        resetn,       // async reset, low
  input  wire logic        ce,           // clock enable
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb enable
  input  wire logic        pwrite,       // apb direction
  input  wire logic [11:0] paddr,        // apb address
  input  wire logic [31:0] pwdata,       // apb write data
  output logic      [31:0] prdata,       // apb read data
  output logic             pready,       // apb ready
  output logic             pslverr,      // apb error
  output logic      [15:0] mem_addr,     // processor bus address
  output logic             mem_rd,       // read cycle
  output logic             mem_wr,       // write cycle
  output logic      [7:0]  mem_wdata,    // write data
  input  wire logic [7:0]  mem_rdata,    // read data
  input  wire logic        irq_req,      // interrupt request level
  output logic             wait_active   // halted awaiting interrupt
);
  ////////////////////////////////////////////////////////////////////////
  // state
  cod_pkg::cod_state_t state_reg, state_next;     // sequencer
  logic [15:0] pc_reg, pc_next;                   // program counter
  logic [15:0] sp_reg, sp_next;                   // stack pointer
  logic [15:0] x_reg, x_next;                     // index x
  logic [15:0] y_reg, y_next;                     // index y
  logic [7:0]  a_reg, a_next;                     // accumulator a
  logic [7:0]  b_reg, b_next;                     // accumulator b
  logic [7:0]  ccr_reg, ccr_next;                 // flag register
  logic [7:0]  op_reg, op_next;                   // current opcode
  logic [7:0]  page_reg, page_next;               // prebyte seen
  logic [15:0] ea_reg, ea_next;                   // effective address
  logic [7:0]  hi_reg, hi_next;                   // held high byte
  logic [3:0]  cnt_reg, cnt_next;                 // internal cycle count
  logic [1:0]  ctrl_reg, ctrl_next;               // run, test enable
  logic [15:0] addr_reg, addr_next;               // bus address
  logic        rd_reg, rd_next;                   // bus read
  logic        wr_reg, wr_next;                   // bus write
  logic [7:0]  wdata_reg, wdata_next;             // bus write data
  logic [31:0] prdata_reg;                        // apb read data
  logic        pready_reg;                        // apb ready
  logic        pslverr_reg;                       // apb error
  logic        wait_reg;                          // wait output

  ////////////////////////////////////////////////////////////////////////
  // decode
  wire         in_opc   = (state_reg == cod_pkg::ST_OPC);
  wire  [7:0]  opc      = in_opc ? mem_rdata : op_reg;     // live opcode
  wire  [1:0]  amode    = opc[5:4];
  wire         is_pre   = in_opc && (page_reg == 8'h00) && ((mem_rdata == `COD_PRE_Y)
                          || (mem_rdata == `COD_PRE_1A) || (mem_rdata == `COD_PRE_CD));
  wire         not_imm  = (amode != cod_pkg::AM_IMM);
  wire         is_sbc   = (opc[7:6] == 2'h2) && (opc[3:0] == 4'h2);
  wire         is_subtract_word_double  = (opc[7:6] == 2'h2) && (opc[3:0] == 4'h3);
  wire         is_std   = (opc[7:6] == 2'h3) && (opc[3:0] == 4'hd) && not_imm;
  wire         is_sts   = (opc[7:6] == 2'h2) && (opc[3:0] == 4'hf) && not_imm;
  wire         is_stxy  = (opc[7:6] == 2'h3) && (opc[3:0] == 4'hf) && not_imm;
  wire         is_store = is_std || is_sts || is_stxy;
  wire         is_mem   = is_sbc || is_subtract_word_double || is_store;
  // index y under 18 or cd pages, x otherwise
  wire         use_y    = (page_reg == `COD_PRE_Y) || (page_reg == `COD_PRE_CD);
  wire  [15:0] idx_val  = use_y ? y_reg : x_reg;
  // stored word: y under 18 or 1a pages for the index store
  wire         val_y    = (page_reg == `COD_PRE_Y) || (page_reg == `COD_PRE_1A);
  wire  [15:0] st_word  = is_std ? {a_reg, b_reg} : is_sts ? sp_reg : val_y ? y_reg : x_reg;
  wire  [15:0] pc_inc   = pc_reg + 16'h0001;
  wire  [15:0] br_dest  = pc_inc + {{8{mem_rdata[7]}}, mem_rdata};
  wire  [15:0] idx_ea   = idx_val + {8'h00, mem_rdata};
  wire  [15:0] dacc     = {a_reg, b_reg};
  wire         run      = ctrl_reg[`COD_CTRL_RUN];
  wire         test_en  = ctrl_reg[`COD_CTRL_TEST];
  // apb decode
  wire         apb_setup = psel && !penable;
  wire         apb_wr    = psel && penable && pready_reg && pwrite;
  wire         cpu_idle  = (state_reg == cod_pkg::ST_IDLE);
  wire  [15:0] wd16      = pwdata[15:0];
  wire  [7:0]  wd8       = pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////
  // subtractors
  logic [7:0]  s8_res;                            // byte difference
  logic        s8_n, s8_z, s8_v, s8_c;            // byte flags
  logic [15:0] s16_res;                           // word difference
  logic        s16_n, s16_z, s16_v, s16_c;        // word flags

  // a minus memory minus carry
  cod_sub #(.W(8)) u_sub8 (
    .a   (a_reg),
    .b   (mem_rdata),
    .cin (ccr_reg[`COD_CCR_C]),
    .res (s8_res),
    .n   (s8_n),
    .z   (s8_z),
    .v   (s8_v),
    .c   (s8_c)
  );

  // double accumulator minus memory word
  cod_sub #(.W(16)) u_sub16 (
    .a   (dacc),
    .b   ({hi_reg, mem_rdata}),
    .cin (1'b0),
    .res (s16_res),
    .n   (s16_n),
    .z   (s16_z),
    .v   (s16_v),
    .c   (s16_c)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb read mux
  logic [31:0] rd_word;                           // selected register
  logic        rd_hit;                            // mapped offset
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      `COD_OFF_CTRL:   rd_word = {30'h0000_0000, ctrl_reg};
      `COD_OFF_STATUS: rd_word = {26'h000_0000, (state_reg == cod_pkg::ST_TEST), wait_reg, state_reg};
      `COD_OFF_DACC:   rd_word = {16'h0000, dacc};
      `COD_OFF_IDX_X:  rd_word = {16'h0000, x_reg};
      `COD_OFF_IDX_Y:  rd_word = {16'h0000, y_reg};
      `COD_OFF_STACK:  rd_word = {16'h0000, sp_reg};
      `COD_OFF_PC:     rd_word = {16'h0000, pc_reg};
      `COD_OFF_FLAGS:  rd_word = {24'h00_0000, ccr_reg};
      default:         rd_hit  = 1'b0;       // unmapped: zero, error
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer next state
  logic        fetch_now;                         // instruction done
  logic        access_now;                        // operand address ready
  logic [7:0]  stk_byte;                          // byte to push
  logic [3:0]  stk_idx;                           // push index
  always_comb begin
    fetch_now  = 1'b0;
    access_now = 1'b0;
    stk_byte   = 8'h00;
    stk_idx    = 4'h0;
    state_next = state_reg;
    pc_next = pc_reg;   sp_next = sp_reg;   x_next = x_reg;   y_next = y_reg;
    a_next = a_reg;     b_next = b_reg;     ccr_next = ccr_reg;
    op_next = op_reg;   page_next = page_reg;   ea_next = ea_reg;   hi_next = hi_reg;
    cnt_next = cnt_reg; ctrl_next = ctrl_reg;   addr_next = addr_reg;
    rd_next = 1'b0;     wr_next = 1'b0;     wdata_next = wdata_reg;
    case (state_reg)
      cod_pkg::ST_IDLE: begin                 // halted, software owns registers
        fetch_now = run;
      end
      cod_pkg::ST_OPC: begin                  // opcode byte on the bus
        pc_next = pc_inc;
        op_next = mem_rdata;
        if (is_pre) begin                     // prebyte adds one fetch cycle
          page_next  = mem_rdata;
          addr_next  = pc_inc;
          rd_next    = 1'b1;
        end else if (is_mem || (mem_rdata == `COD_OP_BRA)) begin
          state_next = cod_pkg::ST_OP1;
          addr_next  = pc_inc;
          rd_next    = 1'b1;
        end else if (mem_rdata == `COD_OP_TSX) begin
          if (use_y) y_next = sp_reg + 16'h0001;
          else       x_next = sp_reg + 16'h0001;
          state_next = cod_pkg::ST_INT;
          cnt_next   = 4'h1;                  // three cycles, four with prebyte
        end else if (mem_rdata == `COD_OP_TXS) begin
          sp_next    = idx_val - 16'h0001;
          state_next = cod_pkg::ST_INT;
          cnt_next   = 4'h1;
        end else if (mem_rdata == `COD_OP_TAP) begin
          ccr_next   = {a_reg[7], a_reg[6] & ccr_reg[`COD_CCR_X], a_reg[5:0]};
          state_next = cod_pkg::ST_INT;
          cnt_next   = 4'h0;
        end else if (mem_rdata == `COD_OP_WAI) begin
          state_next = cod_pkg::ST_STACK;
          cnt_next   = 4'h0;
        end else if ((mem_rdata == `COD_OP_TEST) && test_en) begin
          state_next = cod_pkg::ST_TEST;
          addr_next  = pc_inc;
          rd_next    = 1'b1;
        end else begin                        // unsupported: two-cycle no-op
          state_next = cod_pkg::ST_INT;
          cnt_next   = 4'h0;
        end
      end
      cod_pkg::ST_OP1: begin                  // first operand byte
        pc_next = pc_inc;
        if (opc == `COD_OP_BRA) begin
          pc_next    = br_dest;
          state_next = cod_pkg::ST_INT;
          cnt_next   = 4'h0;
        end else begin
          case (amode)
            cod_pkg::AM_IMM: begin
              if (is_sbc) begin               // one data byte
                a_next    = s8_res;
                ccr_next[3:0] = {s8_n, s8_z, s8_v, s8_c};
                fetch_now = 1'b1;
              end else begin                  // word: high byte first
                hi_next    = mem_rdata;
                state_next = cod_pkg::ST_OP2;
                addr_next  = pc_inc;
                rd_next    = 1'b1;
              end
            end
            cod_pkg::AM_DIR: begin
              ea_next    = {8'h00, mem_rdata};
              access_now = 1'b1;
            end
            cod_pkg::AM_EXT: begin
              hi_next    = mem_rdata;         // address high byte first
              state_next = cod_pkg::ST_OP2;
              addr_next  = pc_inc;
              rd_next    = 1'b1;
            end
            default: begin                    // indexed: one add cycle
              ea_next    = idx_ea;
              state_next = cod_pkg::ST_IDX;
            end
          endcase
        end
      end
      cod_pkg::ST_OP2: begin                  // second operand byte
        pc_next = pc_inc;
        if (amode == cod_pkg::AM_IMM) begin
          {a_next, b_next} = s16_res;
          ccr_next[3:0] = {s16_n, s16_z, s16_v, s16_c};
          state_next = cod_pkg::ST_INT;
          cnt_next   = 4'h0;
        end else begin
          ea_next    = {hi_reg, mem_rdata};
          access_now = 1'b1;
        end
      end
      cod_pkg::ST_IDX: begin                  // index add done
        access_now = 1'b1;
      end
      cod_pkg::ST_RD1: begin                  // memory byte at ea
        if (is_sbc) begin
          a_next    = s8_res;
          ccr_next[3:0] = {s8_n, s8_z, s8_v, s8_c};
          fetch_now = 1'b1;
        end else begin
          hi_next    = mem_rdata;
          state_next = cod_pkg::ST_RD2;
          addr_next  = ea_reg + 16'h0001;
          rd_next    = 1'b1;
        end
      end
      cod_pkg::ST_RD2: begin                  // low byte at ea+1
        {a_next, b_next} = s16_res;
        ccr_next[3:0] = {s16_n, s16_z, s16_v, s16_c};
        state_next = cod_pkg::ST_INT;
        cnt_next   = 4'h0;
      end
      cod_pkg::ST_WR1: begin                  // high byte written, low next
        ccr_next[`COD_CCR_N] = st_word[15];
        ccr_next[`COD_CCR_Z] = (st_word == 16'h0000);
        ccr_next[`COD_CCR_V] = 1'b0;
        state_next = cod_pkg::ST_WR2;
        addr_next  = ea_reg + 16'h0001;
        wdata_next = st_word[7:0];
        wr_next    = 1'b1;
      end
      cod_pkg::ST_WR2: begin
        fetch_now = 1'b1;
      end
      cod_pkg::ST_INT: begin                  // internal cycles
        cnt_next  = cnt_reg - 4'h1;
        fetch_now = (cnt_reg == 4'h0);
        if (cnt_reg != 4'h0) state_next = cod_pkg::ST_INT;
      end
      cod_pkg::ST_STACK: begin                // two internal then nine pushes
        if (cnt_reg >= 4'(`COD_WAI_CYC - 1 - `COD_STACK_BYTES)) sp_next = sp_reg - 16'h0001;
        if (cnt_reg == 4'(`COD_WAI_CYC - 2)) begin
          state_next = cod_pkg::ST_WAIT;
        end else begin
          cnt_next = cnt_reg + 4'h1;
          stk_idx  = cnt_reg + 4'h1 - 4'(`COD_WAI_CYC - 1 - `COD_STACK_BYTES);
          if (cnt_reg + 4'h1 >= 4'(`COD_WAI_CYC - 1 - `COD_STACK_BYTES)) begin
            case (stk_idx)
              4'h0:    stk_byte = pc_reg[7:0];
              4'h1:    stk_byte = pc_reg[15:8];
              4'h2:    stk_byte = y_reg[7:0];
              4'h3:    stk_byte = y_reg[15:8];
              4'h4:    stk_byte = x_reg[7:0];
              4'h5:    stk_byte = x_reg[15:8];
              4'h6:    stk_byte = b_reg;
              4'h7:    stk_byte = a_reg;
              default: stk_byte = ccr_reg;
            endcase
            addr_next  = (cnt_reg >= 4'(`COD_WAI_CYC - 1 - `COD_STACK_BYTES)) ? sp_reg - 16'h0001 : sp_reg;
            wdata_next = stk_byte;
            wr_next    = 1'b1;
          end
        end
      end
      cod_pkg::ST_WAIT: begin                 // whole cycles until recognized
        if (irq_req && !ccr_reg[`COD_CCR_I]) begin
          ccr_next[`COD_CCR_I] = 1'b1;
          state_next = cod_pkg::ST_VEC1;
          addr_next  = VEC_ADDR;
          rd_next    = 1'b1;
        end
      end
      cod_pkg::ST_VEC1: begin                 // vector high byte
        hi_next    = mem_rdata;
        state_next = cod_pkg::ST_VEC2;
        addr_next  = VEC_ADDR + 16'h0001;
        rd_next    = 1'b1;
      end
      cod_pkg::ST_VEC2: begin                 // vector low byte
        pc_next   = {hi_reg, mem_rdata};
        fetch_now = 1'b1;
      end
      cod_pkg::ST_TEST: begin                 // address counts until reset
        addr_next = addr_reg + 16'h0001;
        rd_next   = 1'b1;
      end
      default: state_next = cod_pkg::ST_IDLE;
    endcase
    // operand address known: start data access
    if (access_now) begin
      addr_next = ea_next;
      if (is_store) begin
        state_next = cod_pkg::ST_WR1;
        wdata_next = st_word[15:8];           // high byte first, a for std
        wr_next    = 1'b1;
      end else begin
        state_next = cod_pkg::ST_RD1;
        rd_next    = 1'b1;
      end
    end
    // instruction end: next fetch or halt
    if (fetch_now) begin
      page_next = 8'h00;
      if (run) begin
        state_next = cod_pkg::ST_OPC;
        addr_next  = pc_next;
        rd_next    = 1'b1;
      end else begin
        state_next = cod_pkg::ST_IDLE;
      end
    end
    // software access
    if (apb_wr) begin
      if (paddr == `COD_OFF_CTRL) ctrl_next = pwdata[1:0];
      if (cpu_idle) begin
        case (paddr)
          `COD_OFF_DACC:  {a_next, b_next} = wd16;
          `COD_OFF_IDX_X: x_next   = wd16;
          `COD_OFF_IDX_Y: y_next   = wd16;
          `COD_OFF_STACK: sp_next  = wd16;
          `COD_OFF_PC:    pc_next  = wd16;
          `COD_OFF_FLAGS: ccr_next = wd8;
          default:        ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // core registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= cod_pkg::ST_IDLE;
      pc_reg <= `COD_PC_RST;  sp_reg <= `COD_SP_RST;  x_reg <= 16'h0000;  y_reg <= 16'h0000;
      a_reg <= 8'h00;  b_reg <= 8'h00;  ccr_reg <= `COD_CCR_RST;  op_reg <= 8'h00;
      page_reg <= 8'h00;  ea_reg <= 16'h0000;  hi_reg <= 8'h00;  cnt_reg <= 4'h0;
      ctrl_reg <= `COD_CTRL_RST;  addr_reg <= 16'h0000;  rd_reg <= 1'b0;  wr_reg <= 1'b0;
      wdata_reg <= 8'h00;  wait_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      pc_reg <= pc_next;  sp_reg <= sp_next;  x_reg <= x_next;  y_reg <= y_next;
      a_reg <= a_next;  b_reg <= b_next;  ccr_reg <= ccr_next;  op_reg <= op_next;
      page_reg <= page_next;  ea_reg <= ea_next;  hi_reg <= hi_next;  cnt_reg <= cnt_next;
      ctrl_reg <= ctrl_next;  addr_reg <= addr_next;  rd_reg <= rd_next;  wr_reg <= wr_next;
      wdata_reg <= wdata_next;  wait_reg <= (state_next == cod_pkg::ST_WAIT);
    end
  end

  // apb answer: ready in the cycle after setup
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (ce) begin
      pready_reg  <= apb_setup;
      pslverr_reg <= apb_setup && !rd_hit;
      prdata_reg  <= apb_setup ? rd_word : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign mem_addr    = addr_reg;
  assign mem_rd      = rd_reg;
  assign mem_wr      = wr_reg;
  assign mem_wdata   = wdata_reg;
  assign wait_active = wait_reg;
endmodule

// ==== sim/cod_mem.sv ====
// processor bus memory, answers in the same cycle
module cod_mem (
  input  wire logic        clk,   // bus clock
  input  wire logic [15:0] addr,  // bus address
  input  wire logic        rd,    // read cycle
  input  wire logic        wr,    // write cycle
  input  wire logic [7:0]  wdata, // write data
  output logic      [7:0]  rdata  // read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ram [0:65535]; // whole address space
  // idle bus shows a moving pattern, never the last byte
  assign rdata = rd ? ram[addr] : ~addr[7:0];
  // fill with a harmless two-cycle opcode
  initial for (int i = 0; i < 65536; i++) ram[i] = 8'h01;
  always @(posedge clk) if (wr) ram[addr] <= wdata;
endmodule

// ==== sim/cod_core_asserts.sv ====
module cod_core_asserts #(
  parameter logic [15:0] VEC_ADDR = 16'hfff2 // vector address
) (
  input wire logic        ref_clk,     // clock
  input wire logic        resetn,      // reset, low
  input wire logic        psel,        // apb select
  input wire logic        penable,     // apb enable
  input wire logic        pready,      // apb ready
  input wire logic        pslverr,     // apb error
  input wire logic [15:0] mem_addr,    // bus address
  input wire logic        mem_rd,      // read cycle
  input wire logic        mem_wr,      // write cycle
  input wire logic        irq_req,     // interrupt level
  input wire logic        wait_active  // waiting
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  apb_ready_a: assert property (psel && !penable |=> pready) else $error("pready missing");
  ready_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("stray pready");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  bus_excl_a: assert property (!(mem_rd && mem_wr)) else $error("read and write together");
  wait_hold_a: assert property (wait_active && !irq_req && !$past(irq_req) |=> wait_active)
    else $error("wait left without interrupt");
  wait_quiet_a: assert property (wait_active |-> !mem_wr && !mem_rd) else $error("bus busy in wait");
  vec_fetch_a: assert property ($fell(wait_active) |-> ##[0:1] (mem_rd && mem_addr == VEC_ADDR)
    ##1 (mem_rd && mem_addr == VEC_ADDR + 16'h1)) else $error("vector fetch wrong");
  stack_len_a: assert property ($rose(wait_active) |-> $past(mem_wr) && $past(mem_wr, 9)
    && !$past(mem_wr, 10) && $past(mem_rd, 12)) else $error("stacking length wrong");
  stack_down_a: assert property ($rose(wait_active) |-> $past(mem_addr) + 16'h1 == $past(mem_addr, 2))
    else $error("stacking not downward");
endmodule
bind cod_core cod_core_asserts #(.VEC_ADDR(VEC_ADDR)) u_chk (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
  .irq_req(irq_req), .wait_active(wait_active));

// ==== sim/cod_core_bench.sv ====
module cod_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, resetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, irq_req = 0, err_s;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, mem_rd, mem_wr, wait_active;
  logic [15:0] mem_addr, a;
  logic [7:0] mem_wdata, mem_rdata;
  int num_errors = 0, compares = 0;
  always #25 ref_clk = ~ref_clk;
  cod_core uut (.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .irq_req(irq_req),
    .wait_active(wait_active));
  cod_mem mem (.clk(ref_clk), .addr(mem_addr), .rd(mem_rd), .wr(mem_wr), .wdata(mem_wdata), .rdata(mem_rdata));
  task conclude;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    err_s = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1, ad, d);
  endtask
  task rc(input string n, input logic [11:0] ad, input logic [31:0] e);
    apb(0, ad, 0);
    chk(n, e, r);
  endtask
  // stop the core and wait for the idle state
  task stop;
    wr(12'h000, 0);
    for (int k = 0; k < 20; k++) begin
      apb(0, 12'h004, 0);
      if (r[3:0] === 4'h0) break;
    end
  endtask
  task wf(input logic [15:0] x);
    for (int k = 0; k < 300; k++) begin
      @(posedge ref_clk);
      if (mem_rd === 1'b1 && mem_addr === x) break;
    end
    chk("fetch", {16'h0, x}, {16'h0, mem_addr});
  endtask
  task t_regs;
    rc("flags", 12'h01c, 32'hd0);
    rc("stack", 12'h014, 32'hff);
    apb(0, 12'h020, 0);
    chk("unmapped err", 1, {31'h0, err_s});
    chk("unmapped data", 0, r);
    $display("t_regs done");
  endtask
  // sbc, tap, std dir and y-indexed, tys, tsx, sts ext, subtract_word_double dir, bra self
  task t_prog;
    logic [143:0] p;
    p = 144'h821006dd4018edf0183530bf1234932020fe;
    for (int i = 0; i < 18; i++) mem.ram[i] = p[8*(17-i) +: 8];
    mem.ram[16'h21] = 8'h01;
    mem.ram[16'h20] = 8'h00;
    wr(12'h008, 32'h8000);
    wr(12'h010, 32'h0200);
    wr(12'h01c, 32'h01);
    wr(12'h000, 1);
    wf(16'h0010);
    wf(16'h0010);
    stop;
    rc("dacc", 12'h008, 32'h6eff);
    rc("idx_x", 12'h00c, 32'h0200);
    rc("stack", 12'h014, 32'h01ff);
    rc("flags", 12'h01c, 32'h20);
    chk("std dir", 32'h6f00, {16'h0, mem.ram[16'h40], mem.ram[16'h41]});
    chk("std y", 32'h6f00, {16'h0, mem.ram[16'h2f0], mem.ram[16'h2f1]});
    chk("sts ext", 32'h01ff, {16'h0, mem.ram[16'h1234], mem.ram[16'h1235]});
    $display("t_prog done");
  endtask
  // word immediate, then the 1a and cd pages
  task t_page;
    logic [87:0] q;
    q = 88'h8301001aef10cdef2020fe;
    for (int i = 0; i < 11; i++) mem.ram[16'h500 + i] = q[8*(10-i) +: 8];
    wr(12'h018, 32'h0500);
    wr(12'h010, 32'h0600);
    wr(12'h000, 1);
    wf(16'h0509);
    stop;
    rc("dacc imm", 12'h008, 32'h6dff);
    chk("sty x idx", 32'h0600, {16'h0, mem.ram[16'h210], mem.ram[16'h211]});
    chk("stx y idx", 32'h0200, {16'h0, mem.ram[16'h620], mem.ram[16'h621]});
    $display("t_page done");
  endtask
  task t_wai;
    mem.ram[16'h0300] = 8'h3e;
    mem.ram[16'hfff2] = 8'h03;
    mem.ram[16'hfff3] = 8'h10;
    mem.ram[16'h0310] = 8'h20;
    mem.ram[16'h0311] = 8'hfe;
    wr(12'h018, 32'h0300);
    wr(12'h014, 32'h00ff);
    wr(12'h01c, 32'h00);
    wr(12'h000, 1);
    for (int k = 0; k < 40 && wait_active !== 1'b1; k++) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    chk("waiting", 1, {31'h0, wait_active});
    irq_req <= 1;
    wf(16'h0310);
    irq_req <= 0;
    stop;
    rc("stack", 12'h014, 32'hf6);
    rc("flags", 12'h01c, 32'h10);
    chk("pcl", 32'h01, {24'h0, mem.ram[16'h00ff]});
    chk("acc a", 32'h6d, {24'h0, mem.ram[16'h00f8]});
    chk("flags", 32'h00, {24'h0, mem.ram[16'h00f7]});
    $display("t_wai done");
  endtask
  task t_sweep;
    mem.ram[16'h0400] = 8'h00;
    wr(12'h018, 32'h0400);
    wr(12'h000, 1);
    stop;
    rc("no sweep", 12'h004, 32'h0);
    wr(12'h018, 32'h0400);
    wr(12'h000, 3);
    for (int k = 0; k < 20 && !(mem_rd === 1'b1 && mem_addr > 16'h0402); k++) @(posedge ref_clk);
    a = mem_addr;
    @(posedge ref_clk);
    chk("sweep", {16'h0, a + 16'h1}, {16'h0, mem_addr});
    ce <= 0;
    @(posedge ref_clk);
    a = mem_addr;
    repeat (3) @(posedge ref_clk);
    chk("ce hold", {16'h0, a}, {16'h0, mem_addr});
    resetn <= 0;
    @(posedge ref_clk);
    @(posedge ref_clk);
    chk("reset stop", 0, {31'h0, mem_rd});
    resetn <= 1;
    ce <= 1;
    $display("t_sweep done");
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1;
    t_regs;
    t_prog;
    t_page;
    t_wai;
    t_sweep;
    conclude;
  end
  initial begin
    #150000;
    num_errors++;
    conclude;
  end
endmodule
